// >>> rtl/amsc_axis_ctrl.v
// Mode selection and start qualification for one positioning channel
`timescale 1ns/1ps
`include "amsc_defs.vh"
module amsc_axis_ctrl (
	// Clock and reset
	input  wire        ref_clk,
	input  wire        reset_n,
	// Avalon-MM slave
	input  wire [7:0]  avs_address,
	input  wire        avs_read,
	input  wire        avs_write,
	input  wire [31:0] avs_writedata,
	input  wire [3:0]  avs_byteenable,
	output reg  [31:0] avs_readdata,
	output reg         avs_waitrequest,
	// Pins
	input  wire        enableIn,
	input  wire        jogKeyPos,
	input  wire        jogKeyNeg,
	input  wire        stopIn,
	// Drive outputs
	output reg         movePos,
	output reg         moveNeg,
	output reg         creepSpeed
);
	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	wire enableSync;
	wire keyPosSync;
	wire keyNegSync;
	wire stopSync;

	amsc_sync2 uSyncEn (
		.ref_clk (ref_clk),
		.reset_n (reset_n),
		.asyncIn (enableIn),
		.syncOut (enableSync)
	);
	amsc_sync2 uSyncKp (
		.ref_clk (ref_clk),
		.reset_n (reset_n),
		.asyncIn (jogKeyPos),
		.syncOut (keyPosSync)
	);
	amsc_sync2 uSyncKm (
		.ref_clk (ref_clk),
		.reset_n (reset_n),
		.asyncIn (jogKeyNeg),
		.syncOut (keyNegSync)
	);
	amsc_sync2 uSyncStop (
		.ref_clk (ref_clk),
		.reset_n (reset_n),
		.asyncIn (stopIn),
		.syncOut (stopSync)
	);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	reg [`AMSC_CTRL_W-1:0] ctrl_q;
	reg [`AMSC_MODE_W-1:0] mode_q;
	reg [`AMSC_MODE_W-1:0] mode_d;
	reg [31:0]             target_q;
	reg [31:0]             actual_q;
	reg [31:0]             shift_q;
	reg [31:0]             setVal_q;
	reg [31:0]             check_q;
	reg [31:0]             limLo_q;
	reg [31:0]             limHi_q;
	reg [31:0]             goal_q;
	reg                    sync_q;
	reg                    loopOn_q;
	reg                    noEnable_q;
	reg                    loopNeg_q;
	reg                    reject_q;
	reg                    keyPosPrev_q;
	reg                    keyNegPrev_q;
	reg                    busAck_q;

	wire paramOk  = ctrl_q[`AMSC_CTRL_PARAM];
	wire driveEn  = ctrl_q[`AMSC_CTRL_DRVEN];
	wire busReq   = (avs_read | avs_write) & ~busAck_q;
	wire wrStrobe = avs_write & ~busAck_q;
	wire cmdWr    = wrStrobe & avs_byteenable[0] & (avs_address == `AMSC_REG_CMD);
	wire [31:0] cmdBits = cmdWr ? avs_writedata : `AMSC_ZERO32;

	// Start commands, register ones are single pulses, keys are edge detected
	wire keyPosEdge = keyPosSync & ~keyPosPrev_q;
	wire keyNegEdge = keyNegSync & ~keyNegPrev_q;
	wire startJogP  = cmdBits[`AMSC_CMD_JOGP] | keyPosEdge;
	wire startJogM  = cmdBits[`AMSC_CMD_JOGM] | keyNegEdge;
	wire startRel   = cmdBits[`AMSC_CMD_RELSTART];
	wire startAbs   = cmdBits[`AMSC_CMD_ABSSTART];
	wire startRef   = cmdBits[`AMSC_CMD_REFSTART];
	wire anyStart   = startJogP | startJogM | startRel | startAbs | startRef;
	wire anySetting = cmdBits[`AMSC_CMD_SETACT] | cmdBits[`AMSC_CMD_CLRSHIFT] |
	                  cmdBits[`AMSC_CMD_SETREF] | cmdBits[`AMSC_CMD_LOOPON] |
	                  cmdBits[`AMSC_CMD_NOENON];

	// Start qualification
	wire enableOk  = enableSync | noEnable_q;
	wire idle      = (mode_q == `AMSC_MODE_IDLE);
	wire startOk   = paramOk & idle & driveEn & enableOk;
	wire settingOk = paramOk;

	// Jog, traverse and reference end conditions
	wire atHi     = sync_q & ($signed(actual_q) >= $signed(limHi_q));
	wire atLo     = sync_q & ($signed(actual_q) <= $signed(limLo_q));
	wire stopReq  = stopSync | cmdBits[`AMSC_CMD_STOP];
	wire atGoal   = (actual_q == goal_q);
	wire abortReq = stopReq | ~driveEn | ~paramOk;
	wire jogPosEnd = (~keyPosSync & ~cmdWr) | abortReq | atHi;
	wire jogNegEnd = (~keyNegSync & ~cmdWr) | abortReq | atLo;
	wire refDone  = (mode_q == `AMSC_MODE_REF) & atGoal & ~abortReq;

	// ----------------------------------------------------------------
	// Traverse direction
	// ----------------------------------------------------------------
	// Position after this edge, so the drive drops before the goal is passed
	reg  [31:0] actualNext;
	always @* begin
		actualNext = actual_q;
		if (movePos)
			actualNext = actual_q + `AMSC_STEP;
		else if (moveNeg)
			actualNext = actual_q - `AMSC_STEP;
	end
	wire goalAbove = ($signed(goal_q) > $signed(actualNext));
	wire goalBelow = ($signed(goal_q) < $signed(actualNext));

	// ----------------------------------------------------------------
	// Status word and read mux
	// ----------------------------------------------------------------
	reg  [31:0] statusWord;
	reg  [31:0] readMux;
	always @* begin
		statusWord = `AMSC_ZERO32;
		statusWord[`AMSC_ST_MODE_MSB:`AMSC_ST_MODE_LSB] = mode_q;
		statusWord[`AMSC_ST_BUSY]    = ~idle;
		statusWord[`AMSC_ST_SYNC]    = sync_q;
		statusWord[`AMSC_ST_LOOP]    = loopOn_q;
		statusWord[`AMSC_ST_NOEN]    = noEnable_q;
		statusWord[`AMSC_ST_LOOPNEG] = loopNeg_q;
		statusWord[`AMSC_ST_REJECT]  = reject_q;
		statusWord[`AMSC_ST_MOVEP]   = movePos;
		statusWord[`AMSC_ST_MOVEM]   = moveNeg;
		statusWord[`AMSC_ST_CREEP]   = creepSpeed;
		statusWord[`AMSC_ST_ENIN]    = enableSync;
	end
	always @* begin
		readMux = `AMSC_ZERO32;
		case (avs_address)
			`AMSC_REG_CTRL:   readMux = {29'h0, ctrl_q};
			`AMSC_REG_STATUS: readMux = statusWord;
			`AMSC_REG_TARGET: readMux = target_q;
			`AMSC_REG_ACTUAL: readMux = actual_q + shift_q;
			`AMSC_REG_SHIFT:  readMux = shift_q;
			`AMSC_REG_SETVAL: readMux = setVal_q;
			`AMSC_REG_CHECK:  readMux = check_q;
			`AMSC_REG_LIMLO:  readMux = limLo_q;
			`AMSC_REG_LIMHI:  readMux = limHi_q;
			`AMSC_REG_DEVID:  readMux = `AMSC_DEVID_VAL;
			default:          readMux = `AMSC_ZERO32;
		endcase
	end

	// ----------------------------------------------------------------
	// Bus handshake, one wait cycle per access
	// ----------------------------------------------------------------
	always @(posedge ref_clk) begin
		if (!reset_n) begin
			busAck_q        <= 1'b0;
			avs_readdata    <= `AMSC_ZERO32;
			avs_waitrequest <= 1'b1;
		end else begin
			busAck_q        <= busReq;
			avs_waitrequest <= ~busReq;
			if (avs_read & ~busAck_q)
				avs_readdata <= readMux;
		end
	end

	// ----------------------------------------------------------------
	// Mode machine
	// ----------------------------------------------------------------
	always @* begin
		mode_d = mode_q;
		case (mode_q)
			`AMSC_MODE_IDLE: begin
				if (startOk) begin
					if (startJogP)
						mode_d = `AMSC_MODE_JOGP;
					else if (startJogM)
						mode_d = `AMSC_MODE_JOGM;
					else if (startRel)
						mode_d = `AMSC_MODE_REL;
					else if (startAbs)
						mode_d = `AMSC_MODE_ABS;
					else if (startRef)
						mode_d = `AMSC_MODE_REF;
				end
			end
			`AMSC_MODE_JOGP: begin
				if (jogPosEnd)
					mode_d = `AMSC_MODE_IDLE;
			end
			`AMSC_MODE_JOGM: begin
				if (jogNegEnd)
					mode_d = `AMSC_MODE_IDLE;
			end
			`AMSC_MODE_REL, `AMSC_MODE_ABS: begin
				if (atGoal || abortReq)
					mode_d = `AMSC_MODE_IDLE;
			end
			`AMSC_MODE_REF: begin
				if (abortReq || atGoal)
					mode_d = `AMSC_MODE_IDLE;
			end
			default: mode_d = `AMSC_MODE_IDLE;
		endcase
	end

	// ----------------------------------------------------------------
	// Clocked state, bus and settings
	// ----------------------------------------------------------------
	always @(posedge ref_clk) begin
		if (!reset_n) begin
			ctrl_q          <= {`AMSC_CTRL_W{1'b0}};
			mode_q          <= `AMSC_MODE_IDLE;
			target_q        <= `AMSC_ZERO32;
			actual_q        <= `AMSC_ZERO32;
			shift_q         <= `AMSC_ZERO32;
			setVal_q        <= `AMSC_ZERO32;
			check_q         <= `AMSC_ZERO32;
			limLo_q         <= `AMSC_ZERO32;
			limHi_q         <= `AMSC_ZERO32;
			goal_q          <= `AMSC_ZERO32;
			sync_q          <= 1'b0;
			loopOn_q        <= 1'b0;
			noEnable_q      <= 1'b0;
			loopNeg_q       <= 1'b0;
			reject_q        <= 1'b0;
			keyPosPrev_q    <= 1'b0;
			keyNegPrev_q    <= 1'b0;
			movePos         <= 1'b0;
			moveNeg         <= 1'b0;
			creepSpeed      <= 1'b0;
		end else begin
			keyPosPrev_q <= keyPosSync;
			keyNegPrev_q <= keyNegSync;
			mode_q       <= mode_d;

			if (wrStrobe && avs_byteenable[0]) begin
				case (avs_address)
					`AMSC_REG_CTRL:   ctrl_q   <= avs_writedata[`AMSC_CTRL_W-1:0];
					`AMSC_REG_TARGET: target_q <= avs_writedata;
					`AMSC_REG_SETVAL: setVal_q <= avs_writedata;
					`AMSC_REG_CHECK:  check_q  <= avs_writedata;
					`AMSC_REG_LIMLO:  limLo_q  <= avs_writedata;
					`AMSC_REG_LIMHI:  limHi_q  <= avs_writedata;
					default: ;
				endcase
			end

			// Rejection flag, sticky until the status word is read
			if ((anyStart && !startOk) || (anySetting && !settingOk))
				reject_q <= 1'b1;
			else if (avs_read && !busAck_q && avs_address == `AMSC_REG_STATUS)
				reject_q <= 1'b0;

			// Goal latched at the start of an incremental, absolute or reference traverse
			if (mode_q == `AMSC_MODE_IDLE && startOk) begin
				if (startRel)
					goal_q <= actual_q + target_q;
				else if (startAbs)
					goal_q <= target_q - shift_q;
				else if (startRef)
					goal_q <= actual_q;
			end

			// Physical position follows the drive commands, one step per cycle
			if (movePos)
				actual_q <= actual_q + `AMSC_STEP;
			else if (moveNeg)
				actual_q <= actual_q - `AMSC_STEP;

			// One-shot settings, effect persists
			if (settingOk) begin
				if (cmdBits[`AMSC_CMD_SETACT])
					shift_q <= setVal_q - actual_q;
				else if (cmdBits[`AMSC_CMD_CLRSHIFT])
					shift_q <= `AMSC_ZERO32;
				if (cmdBits[`AMSC_CMD_SETREF] || refDone)
					sync_q <= 1'b1;
				// Single settings stay on until explicitly terminated
				if (cmdBits[`AMSC_CMD_LOOPON]) begin
					loopOn_q  <= 1'b1;
					loopNeg_q <= cmdBits[`AMSC_CMD_LOOPNEG];
				end else if (cmdBits[`AMSC_CMD_LOOPOFF])
					loopOn_q <= 1'b0;
				if (cmdBits[`AMSC_CMD_NOENON])
					noEnable_q <= 1'b1;
				else if (cmdBits[`AMSC_CMD_NOENOFF])
					noEnable_q <= 1'b0;
			end

			// Direction outputs from the next mode, creep output from the control register
			creepSpeed <= ctrl_q[`AMSC_CTRL_CREEP];
			case (mode_d)
				`AMSC_MODE_JOGP: begin
					movePos <= 1'b1;
					moveNeg <= 1'b0;
				end
				`AMSC_MODE_JOGM: begin
					movePos <= 1'b0;
					moveNeg <= 1'b1;
				end
				`AMSC_MODE_REL, `AMSC_MODE_ABS: begin
					if (mode_q == `AMSC_MODE_IDLE) begin
						movePos <= 1'b0;
						moveNeg <= 1'b0;
					end else begin
						movePos <= goalAbove;
						moveNeg <= goalBelow;
					end
				end
				`AMSC_MODE_REF: begin
					movePos <= 1'b0;
					moveNeg <= 1'b0;
				end
				default: begin
					movePos <= 1'b0;
					moveNeg <= 1'b0;
				end
			endcase
		end
	end
endmodule

// >>> rtl/amsc_defs.vh
// Constants, register map and mode codes of the axis mode and start controller
`ifndef AMSC_DEFS_VH
`define AMSC_DEFS_VH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define AMSC_ADDR_W       8
`define AMSC_REG_CTRL     8'h00
`define AMSC_REG_CMD      8'h04
`define AMSC_REG_STATUS   8'h08
`define AMSC_REG_TARGET   8'h0C
`define AMSC_REG_ACTUAL   8'h10
`define AMSC_REG_SHIFT    8'h14
`define AMSC_REG_SETVAL   8'h18
`define AMSC_REG_CHECK    8'h1C
`define AMSC_REG_LIMLO    8'h20
`define AMSC_REG_LIMHI    8'h24
`define AMSC_REG_DEVID    8'h28

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define AMSC_CTRL_PARAM   0
`define AMSC_CTRL_DRVEN   1
`define AMSC_CTRL_CREEP   2
`define AMSC_CTRL_W       3

// ----------------------------------------------------------------
// Command register fields (write one to act)
// ----------------------------------------------------------------
`define AMSC_CMD_JOGP     0
`define AMSC_CMD_JOGM     1
`define AMSC_CMD_RELSTART 2
`define AMSC_CMD_ABSSTART 3
`define AMSC_CMD_REFSTART 4
`define AMSC_CMD_STOP     5
`define AMSC_CMD_SETACT   6
`define AMSC_CMD_CLRSHIFT 7
`define AMSC_CMD_SETREF   8
`define AMSC_CMD_LOOPON   9
`define AMSC_CMD_NOENON   10
`define AMSC_CMD_LOOPOFF  11
`define AMSC_CMD_NOENOFF  12
`define AMSC_CMD_LOOPNEG  13

// ----------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------
`define AMSC_ST_MODE_LSB  0
`define AMSC_ST_MODE_MSB  2
`define AMSC_ST_BUSY      3
`define AMSC_ST_SYNC      4
`define AMSC_ST_LOOP      5
`define AMSC_ST_NOEN      6
`define AMSC_ST_LOOPNEG   7
`define AMSC_ST_REJECT    8
`define AMSC_ST_MOVEP     9
`define AMSC_ST_MOVEM     10
`define AMSC_ST_CREEP     11
`define AMSC_ST_ENIN      12

// ----------------------------------------------------------------
// Mode codes
// ----------------------------------------------------------------
`define AMSC_MODE_W       3
`define AMSC_MODE_IDLE    3'h0
`define AMSC_MODE_JOGP    3'h1
`define AMSC_MODE_JOGM    3'h2
`define AMSC_MODE_REL     3'h3
`define AMSC_MODE_ABS     3'h4
`define AMSC_MODE_REF     3'h5

// ----------------------------------------------------------------
// Misc
// ----------------------------------------------------------------
`define AMSC_POS_W        32
`define AMSC_ZERO32       32'h00000000
`define AMSC_STEP         32'h00000001
// Identification word, value is arbitrary
`define AMSC_DEVID_VAL    32'h0000A5A5

`endif

// >>> rtl/amsc_sync2.v
// Two flip-flop synchroniser for one pin level
`timescale 1ns/1ps
module amsc_sync2 (
	// Clock and reset
	input  wire ref_clk,
	input  wire reset_n,
	// Level in and out
	input  wire asyncIn,
	output reg  syncOut
);
	reg stage1Q;

	always @(posedge ref_clk) begin
		if (!reset_n) begin
			stage1Q <= 1'b0;
			syncOut <= 1'b0;
		end else begin
			stage1Q <= asyncIn;
			syncOut <= stage1Q;
		end
	end
endmodule

// >>> verif/amsc_pins_model.sv
// Pin-side partner: operator keys, stop switch and enable input wiring
`timescale 1ns/1ps
module amsc_pins_model (
	// Clock
	input  wire  ref_clk,
	// Requests from the bench
	input  wire  enReq,
	input  wire  keyPosReq,
	input  wire  keyNegReq,
	input  wire  stopReq,
	// Pins toward the controller
	output logic enableIn,
	output logic jogKeyPos,
	output logic jogKeyNeg,
	output logic stopIn
);
	always @(posedge ref_clk) begin
		enableIn <= enReq;
		jogKeyPos <= keyPosReq;
		jogKeyNeg <= keyNegReq;
		stopIn <= stopReq;
	end
endmodule

// >>> verif/amsc_axis_ctrl_monitor.sv
// Port checker of the axis mode and start controller
`timescale 1ns/1ps
`include "amsc_defs.vh"
module amsc_axis_ctrl_monitor (
	// Clock and reset
	input wire        ref_clk,
	input wire        reset_n,
	// Avalon-MM slave
	input wire [7:0]  avs_address,
	input wire        avs_read,
	input wire        avs_write,
	input wire [31:0] avs_writedata,
	input wire [3:0]  avs_byteenable,
	input wire [31:0] avs_readdata,
	input wire        avs_waitrequest,
	// Pins and drive
	input wire        enableIn,
	input wire        jogKeyPos,
	input wire        jogKeyNeg,
	input wire        stopIn,
	input wire        movePos,
	input wire        moveNeg,
	input wire        creepSpeed
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	// ----------------------------------------------------------------
	// Shadow of control and ignore-enable state, taken at bus answers
	// ----------------------------------------------------------------
	logic paramOn_q;
	logic drvEn_q;
	logic noEn_q;
	wire  acc = avs_write && !avs_waitrequest && avs_byteenable[0];
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			paramOn_q <= 1'b0;
			drvEn_q <= 1'b0;
			noEn_q <= 1'b0;
		end else if (acc && avs_address == `AMSC_REG_CTRL) begin
			paramOn_q <= avs_writedata[0];
			drvEn_q <= avs_writedata[1];
		end else if (acc && avs_address == `AMSC_REG_CMD) begin
			noEn_q <= (noEn_q | avs_writedata[10]) & !avs_writedata[12];
		end
	end
	a_move_one_way: assert property (!(movePos && moveNeg))
		else $error("both directions driven");
	a_need_param_drv: assert property (!(paramOn_q && drvEn_q) |=> !movePos && !moveNeg)
		else $error("motion without parameters or drive enable");
	a_enable_start: assert property (($rose(movePos) || $rose(moveNeg)) && !noEn_q
		|-> $past(enableIn, 2) || $past(enableIn, 3) || $past(enableIn, 4) || $past(enableIn, 5))
		else $error("start with enable input low");
	a_stop_halts: assert property (stopIn [*4] |=> !movePos && !moveNeg)
		else $error("motion continues under stop");
	a_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("no answer after one wait cycle");
	a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low longer than one cycle");
	a_unmapped_zero: assert property (avs_read && !avs_waitrequest && avs_address == 8'h40
		|-> avs_readdata == 32'h0)
		else $error("unmapped read not zero");
	a_cmd_reads_zero: assert property (avs_read && !avs_waitrequest && avs_address == `AMSC_REG_CMD
		|-> avs_readdata == 32'h0)
		else $error("command register read not zero");
	c_pos: cover property ($rose(movePos));
	c_neg: cover property ($rose(moveNeg));
	c_read: cover property (avs_read && !avs_waitrequest);
endmodule
bind amsc_axis_ctrl amsc_axis_ctrl_monitor i_mon (.ref_clk(ref_clk), .reset_n(reset_n),
	.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
	.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
	.enableIn(enableIn), .jogKeyPos(jogKeyPos), .jogKeyNeg(jogKeyNeg), .stopIn(stopIn),
	.movePos(movePos), .moveNeg(moveNeg), .creepSpeed(creepSpeed));

// >>> verif/amsc_axis_ctrl_bench.sv
// Self-checking bench of the axis mode and start controller
`timescale 1ns/1ps
`include "amsc_defs.vh"
module amsc_axis_ctrl_bench;
	typedef struct packed {logic [7:0] a; logic [31:0] v; logic [31:0] e;} amsc_row_t;
	logic        refClk;
	logic        resetN;
	logic [7:0]  adr;
	logic        rdReq;
	logic        wrReq;
	logic [31:0] wdat;
	logic [3:0]  be;
	logic        enR;
	logic        kpR;
	logic        knR;
	logic        stR;
	logic [31:0] d;
	wire  [31:0] rdat;
	wire         wreq;
	wire         enP;
	wire         kpP;
	wire         knP;
	wire         stP;
	wire         mP;
	wire         mN;
	wire         crp;
	int          mismatches;
	int          n_compared;
	int          cyc = 0;
	amsc_row_t   rows [0:7];
	amsc_axis_ctrl i_dut (.ref_clk(refClk), .reset_n(resetN), .avs_address(adr), .avs_read(rdReq),
		.avs_write(wrReq), .avs_writedata(wdat), .avs_byteenable(be), .avs_readdata(rdat),
		.avs_waitrequest(wreq), .enableIn(enP), .jogKeyPos(kpP), .jogKeyNeg(knP), .stopIn(stP),
		.movePos(mP), .moveNeg(mN), .creepSpeed(crp));
	amsc_pins_model i_pins (.ref_clk(refClk), .enReq(enR), .keyPosReq(kpR), .keyNegReq(knR),
		.stopReq(stR), .enableIn(enP), .jogKeyPos(kpP), .jogKeyNeg(knP), .stopIn(stP));
	initial begin
		refClk = 1'b0;
		forever #25 refClk = ~refClk;
	end
	// ----------------------------------------------------------------
	// Bus cycles and comparisons
	// ----------------------------------------------------------------
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] v, output logic [31:0] q);
		adr <= a;
		wrReq <= w;
		rdReq <= !w;
		wdat <= v;
		@(posedge refClk);
		while (wreq !== 1'b0) @(posedge refClk);
		q = rdat;
		wrReq <= 1'b0;
		rdReq <= 1'b0;
		@(posedge refClk);
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string nm);
		bus(1'b0, a, 32'h0, d);
		chk(nm, e, d);
	endtask
	task automatic cmd(input int b);
		bus(1'b1, `AMSC_REG_CMD, 32'h1 << b, d);
	endtask
	task automatic wait_idle;
		d = 32'h7;
		for (int i = 0; i < 300 && d[2:0] !== 3'h0; i++) bus(1'b0, `AMSC_REG_STATUS, 32'h0, d);
	endtask
	task automatic close_out;
		if (mismatches == 0 && n_compared > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	always @(posedge refClk) begin
		cyc++;
		if (cyc > 20000) begin
			mismatches++;
			close_out();
		end
	end
	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		mismatches = 0;
		n_compared = 0;
		{adr, rdReq, wrReq, wdat, be, enR, kpR, knR, stR, resetN} = '0;
		be = 4'hF;
		rows = '{'{`AMSC_REG_CTRL, 32'h3, 32'h3}, '{`AMSC_REG_TARGET, 32'h5, 32'h5},
			'{`AMSC_REG_SETVAL, 32'h64, 32'h64}, '{`AMSC_REG_CHECK, 32'hA5A5, 32'hA5A5},
			'{`AMSC_REG_LIMHI, 32'h3E8, 32'h3E8}, '{8'h40, 32'h1234, 32'h0}, '{`AMSC_REG_CMD, 32'h0, 32'h0},
			'{`AMSC_REG_DEVID, 32'h0, `AMSC_DEVID_VAL}};
		repeat (2) @(posedge refClk);
		resetN <= 1'b1;
		@(posedge refClk);
		rchk(`AMSC_REG_STATUS, 32'h0, "status after reset");
		cmd(`AMSC_CMD_RELSTART);
		rchk(`AMSC_REG_STATUS, 32'h100, "start unparameterized");
		cmd(`AMSC_CMD_SETREF);
		rchk(`AMSC_REG_STATUS, 32'h100, "setting unparameterized");
		foreach (rows[i]) begin
			bus(1'b1, rows[i].a, rows[i].v, d);
			rchk(rows[i].a, rows[i].e, "register row");
		end
		cmd(`AMSC_CMD_RELSTART);
		rchk(`AMSC_REG_STATUS, 32'h100, "start enable pin low");
		enR <= 1'b1;
		bus(1'b1, `AMSC_REG_CTRL, 32'h1, d);
		cmd(`AMSC_CMD_RELSTART);
		rchk(`AMSC_REG_STATUS, 32'h1100, "start drive disabled");
		bus(1'b1, `AMSC_REG_CTRL, 32'h3, d);
		cmd(`AMSC_CMD_RELSTART);
		chk("rel moves pos", 32'h1, 32'(mP));
		wait_idle();
		rchk(`AMSC_REG_ACTUAL, 32'h5, "rel displacement");
		bus(1'b1, `AMSC_REG_TARGET, 32'h0, d);
		cmd(`AMSC_CMD_ABSSTART);
		chk("abs moves neg", 32'h1, 32'(mN));
		wait_idle();
		rchk(`AMSC_REG_ACTUAL, 32'h0, "abs target");
		bus(1'b1, `AMSC_REG_TARGET, 32'hBE, d);
		cmd(`AMSC_CMD_RELSTART);
		knR <= 1'b1;
		repeat (6) @(posedge refClk);
		chk("jog refused while busy", 32'h2, {30'h0, mP, mN});
		knR <= 1'b0;
		cmd(`AMSC_CMD_STOP);
		repeat (2) @(posedge refClk);
		chk("stop command", 32'h0, {30'h0, mP, mN});
		kpR <= 1'b1;
		repeat (6) @(posedge refClk);
		chk("jog key pos", 32'h2, {30'h0, mP, mN});
		stR <= 1'b1;
		repeat (6) @(posedge refClk);
		chk("stop pin", 32'h0, {30'h0, mP, mN});
		stR <= 1'b0;
		repeat (6) @(posedge refClk);
		chk("held key no restart", 32'h0, {30'h0, mP, mN});
		kpR <= 1'b0;
		repeat (4) @(posedge refClk);
		knR <= 1'b1;
		repeat (6) @(posedge refClk);
		chk("jog key neg", 32'h1, {30'h0, mP, mN});
		knR <= 1'b0;
		repeat (6) @(posedge refClk);
		chk("key released", 32'h0, {30'h0, mP, mN});
		cmd(`AMSC_CMD_REFSTART);
		wait_idle();
		chk("synchronised", 32'h1, 32'(d[`AMSC_ST_SYNC]));
		cmd(`AMSC_CMD_SETACT);
		repeat (5) @(posedge refClk);
		rchk(`AMSC_REG_ACTUAL, 32'h64, "shift persists");
		rchk(`AMSC_REG_LIMHI, 32'h3E8, "range unchanged");
		cmd(`AMSC_CMD_CLRSHIFT);
		rchk(`AMSC_REG_SHIFT, 32'h0, "shift cleared");
		bus(1'b1, `AMSC_REG_CMD, 32'h1 << `AMSC_CMD_LOOPON | 32'h1 << `AMSC_CMD_LOOPNEG, d);
		cmd(`AMSC_CMD_REFSTART);
		bus(1'b0, `AMSC_REG_STATUS, 32'h0, d);
		chk("loop settings on", 32'h5, 32'(d[7:5]));
		cmd(`AMSC_CMD_LOOPOFF);
		bus(1'b0, `AMSC_REG_STATUS, 32'h0, d);
		chk("loop off", 32'h0, 32'(d[5]));
		enR <= 1'b0;
		cmd(`AMSC_CMD_NOENON);
		bus(1'b1, `AMSC_REG_TARGET, 32'h20, d);
		cmd(`AMSC_CMD_ABSSTART);
		chk("ignore enable start", 32'h1, 32'(mP));
		wait_idle();
		cmd(`AMSC_CMD_NOENOFF);
		cmd(`AMSC_CMD_RELSTART);
		repeat (2) @(posedge refClk);
		chk("enable evaluated again", 32'h0, 32'(mP));
		// Creep output, then a reset in the middle of a traverse
		bus(1'b1, `AMSC_REG_CTRL, 32'h7, d);
		cmd(`AMSC_CMD_NOENON);
		bus(1'b1, `AMSC_REG_TARGET, 32'h60, d);
		cmd(`AMSC_CMD_RELSTART);
		chk("creep and move", 32'h3, {30'h0, crp, mP});
		resetN <= 1'b0;
		repeat (2) @(posedge refClk);
		chk("outputs in reset", 32'h4, {28'h0, crp, wreq, mP, mN});
		resetN <= 1'b1;
		@(posedge refClk);
		rchk(`AMSC_REG_STATUS, 32'h0, "status after mid reset");
		rchk(`AMSC_REG_ACTUAL, 32'h0, "actual after mid reset");
		close_out();
	end
endmodule
